/* smb_target.sv */
`timescale 1ns/1ps
`include "smb_cfg.svh"
// Operation
// - target only, never starts a transfer
// - clock stretch ends within one millisecond
// - scl low past 25 ms aborts, recovers
// - start and stop resync at any bit
// - runs at up to 100 kbps
// - alert low on any shutdown or warning
// - alert response read returns status byte
// - select resistor picks protocol and address index
// - open select pin gives psmi, top address
// - select pin sampled once after reset
// - eeprom address follows controller at fixed offset
// - address byte lsb is direction bit
// - eeprom writes blocked until protection disabled
// - 256 user bytes, none used internally
// - byte write: address, location, data, stop
// - master waits 5 ms after eeprom write
// - byte read: location, restart, read address
// - master prefers single byte transfers
module smb_target import smb_pkg::*; #(
  parameter int STRETCH_CYC = `SMB_STRETCH_CYC,
  parameter int TIMEOUT_CYC = `SMB_TIMEOUT_CYC,
  parameter int N_EVENTS = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  smb_if.device bus,
  input wire logic [17:0] select_resistor_value,
  input wire logic select_pin_open,
  input wire logic [N_EVENTS-1:0] shutdown_events,
  input wire logic [N_EVENTS-1:0] warning_events,
  input wire logic [7:0] status_byte,
  output proto_t proto,
  output logic [6:0] ctrl_addr,
  output logic [6:0] ee_addr,
  output logic write_protect,
  output logic cmd_valid,
  output logic [7:0] cmd_code
);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int SW = $clog2(STRETCH_CYC + 1);
  logic [17:0] sel_meta, sel_sync;
  logic open_meta, open_sync, strap_taken, rw, master_ack, pend_valid, sda_oe, alert_oe, timeout;
  logic scl_s, sda_s, scl_rise, scl_fall, start_cond, stop_cond;
  logic [1:0] strap_wait, addr_idx, bytepos;
  logic [2:0] strap_code;
  dev_state_t state;
  target_t target;
  logic [3:0] bitcnt;
  logic [7:0] shreg, ptr, pend_addr, pend_data, tx_byte;
  logic [6:0] rx_addr;
  logic [TW-1:0] low_cnt;
  logic [SW-1:0] stretch_cnt;
  logic [7:0] mem [0:255];
  // resistance in ohms to {pmbus, address index}
  function automatic logic [2:0] decode_select(input logic [17:0] ohms, input logic open_pin);
    logic [2:0] code;
    code = {1'b0, `SMB_DEFAULT_IDX}; // open pin: psmi, highest index
    if (!open_pin) begin
      if (ohms < `SMB_TH_01) code = 3'h4;
      else if (ohms < `SMB_TH_12) code = 3'h5;
      else if (ohms < `SMB_TH_23) code = 3'h6;
      else if (ohms < `SMB_TH_PROTO) code = 3'h7;
      else if (ohms < `SMB_TH_45) code = 3'h0;
      else if (ohms < `SMB_TH_56) code = 3'h1;
      else if (ohms < `SMB_TH_67) code = 3'h2;
      else code = 3'h3;
    end
    return code;
  endfunction
  // strap synchroniser; the value is static, so bitwise skew only delays it
  always_ff @(posedge ref_clk) begin
    sel_meta <= select_resistor_value;
    sel_sync <= sel_meta;
    open_meta <= select_pin_open;
    open_sync <= open_meta;
  end
  // one decode feeds both fields, so protocol and index always agree
  assign strap_code = decode_select(sel_sync, open_sync);
  // take the strap once, a few edges after reset release, then never again
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strap_wait <= 2'h0;
      strap_taken <= 1'b0;
      proto <= PROTO_PSMI;
      addr_idx <= `SMB_DEFAULT_IDX;
    end else if (!strap_taken) begin
      if (strap_wait == 2'h3) begin
        strap_taken <= 1'b1;
        proto <= strap_code[2] ? PROTO_PMBUS : PROTO_PSMI;
        addr_idx <= strap_code[1:0];
      end else begin
        strap_wait <= strap_wait + 2'h1;
      end
    end
  end
  // both addresses step together from the one index
  assign ctrl_addr = `SMB_CTRL_BASE + {5'h0, addr_idx};
  assign ee_addr = `SMB_EE_BASE + {5'h0, addr_idx};
  // sampling at 50 MHz leaves wide margin for a 100 kHz bus
  smb_line_sync u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .scl_pin(bus.scl),
    .sda_pin(bus.sda),
    .scl(scl_s),
    .sda(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_cond(start_cond),
    .stop_cond(stop_cond)
  );
  // scl low watchdog; abort leaves the machine idle on the next edge
  always_ff @(posedge ref_clk) begin
    if (reset || scl_s) begin
      low_cnt <= '0;
    end else if (low_cnt != TW'(TIMEOUT_CYC)) begin
      low_cnt <= low_cnt + TW'(1);
    end
  end
  assign timeout = ~scl_s && (low_cnt == TW'(TIMEOUT_CYC - 1));
  // stretch guard: scl is let go once the limit is hit, whatever the load does
  always_ff @(posedge ref_clk) begin
    if (reset || state != S_LOAD) begin
      stretch_cnt <= '0;
    end else if (stretch_cnt != SW'(STRETCH_CYC)) begin
      stretch_cnt <= stretch_cnt + SW'(1);
    end
  end
  assign rx_addr = shreg[7:1];
  assign tx_byte = (target == TGT_EE) ? mem[ptr] : status_byte;
  // byte engine; sda is only ever driven for ack and read data, never for a start
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= S_IDLE;
      target <= TGT_CTRL;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      bytepos <= 2'h0;
      master_ack <= 1'b0;
      ptr <= 8'h00;
      pend_addr <= 8'h00;
      pend_data <= 8'h00;
      pend_valid <= 1'b0;
      sda_oe <= 1'b0;
      write_protect <= 1'b1;
      cmd_valid <= 1'b0;
      cmd_code <= 8'h00;
    end else begin
      cmd_valid <= 1'b0;
      if (timeout || stop_cond) begin
        state <= S_IDLE;
        sda_oe <= 1'b0;
        pend_valid <= 1'b0;
      end else if (start_cond && strap_taken) begin
        state <= S_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
        pend_valid <= 1'b0;
      end else begin
        unique case (state)
          S_IDLE, S_IGNORE: begin
            sda_oe <= 1'b0;
          end
          S_ADDR, S_RX: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              if (state == S_ADDR) begin
                rw <= shreg[0];
                bytepos <= 2'h0;
                state <= S_ACK;
                sda_oe <= 1'b1;
                if (rx_addr == ctrl_addr) begin
                  target <= TGT_CTRL;
                end else if (rx_addr == ee_addr) begin
                  target <= TGT_EE;
                end else if (rx_addr == `SMB_ALERT_RESP_ADDR && shreg[0]) begin
                  target <= TGT_ALERT;
                end else begin
                  state <= S_IGNORE;
                  sda_oe <= 1'b0;
                end
              end else begin
                state <= S_ACK;
                sda_oe <= 1'b1;
                if (bytepos != 2'h3) begin
                  bytepos <= bytepos + 2'h1;
                end
                if (target == TGT_CTRL && bytepos == 2'h0) begin
                  cmd_valid <= 1'b1;
                  cmd_code <= shreg;
                  if (shreg == `SMB_CMD_WP_OFF) write_protect <= 1'b0;
                  if (shreg == `SMB_CMD_WP_ON) write_protect <= 1'b1;
                end else if (target == TGT_EE && bytepos == 2'h0) begin
                  ptr <= shreg;
                end else if (target == TGT_EE && bytepos == 2'h1) begin
                  pend_addr <= ptr;
                  pend_data <= shreg;
                  pend_valid <= 1'b1;
                end
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              bitcnt <= 4'h0;
              state <= rw ? S_LOAD : S_RX;
            end
          end
          S_LOAD: begin
            shreg <= tx_byte;
            sda_oe <= ~tx_byte[7];
            bitcnt <= 4'h0;
            state <= S_TX;
            if (target == TGT_EE) begin
              ptr <= ptr + 8'h01;
            end
          end
          S_TX: begin
            if (scl_rise) begin
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                sda_oe <= 1'b0;
                state <= S_MACK;
              end else begin
                sda_oe <= ~shreg[6];
                shreg <= {shreg[6:0], 1'b0};
              end
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              master_ack <= ~sda_s;
            end else if (scl_fall) begin
              state <= master_ack ? S_LOAD : S_IGNORE;
            end
          end
        endcase
      end
    end
  end

  // eeprom array is pure user storage, committed at the closing stop
  always_ff @(posedge ref_clk) begin
    if (stop_cond && pend_valid && !write_protect) begin
      mem[pend_addr] <= pend_data;
    end
  end

  // alert pin, registered so the wire never glitches
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      alert_oe <= 1'b0;
    end else begin
      alert_oe <= (|shutdown_events) | (|warning_events);
    end
  end

  // scl held low only while a read byte is fetched, capped by the guard
  assign bus.dev_scl_oe = (state == S_LOAD) && (stretch_cnt != SW'(STRETCH_CYC));
  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_sda_oe = sda_oe;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_alert_oe = alert_oe;
  assign bus.dev_alert_o = 1'b0;
endmodule

/* smb_cfg.svh */
`ifndef SMB_CFG_SVH
`define SMB_CFG_SVH

// system clock and bus rate
`define SMB_CLK_HZ 50000000
`define SMB_BIT_RATE_HZ 100000

// target addresses, 7-bit form (direction bit excluded)
`define SMB_CTRL_BASE 7'h58
`define SMB_EE_BASE 7'h50
`define SMB_ALERT_RESP_ADDR 7'h0c
`define SMB_DEFAULT_IDX 2'h3

// controller command codes for eeprom write protection
`define SMB_CMD_WP_OFF 8'hd0
`define SMB_CMD_WP_ON 8'hd1

// select resistor decision thresholds in ohms, midway between fitted values
`define SMB_TH_01 18'd1760
`define SMB_TH_12 18'd4150
`define SMB_TH_23 18'd6900
`define SMB_TH_PROTO 18'd11600
`define SMB_TH_45 18'd21000
`define SMB_TH_56 18'd41500
`define SMB_TH_67 18'd118000

// times in their own units
`define SMB_STRETCH_MAX_MS 1
`define SMB_TIMEOUT_MS 25
`define SMB_EE_WRITE_MS 5
`define SMB_HALF_BIT_NS 5000

// derived cycle counts
`define SMB_CYC_PER_MS (`SMB_CLK_HZ / 1000)
`define SMB_STRETCH_CYC (`SMB_STRETCH_MAX_MS * `SMB_CYC_PER_MS)
`define SMB_TIMEOUT_CYC (`SMB_TIMEOUT_MS * `SMB_CYC_PER_MS + 1)
`define SMB_BUS_FREE_CYC (`SMB_EE_WRITE_MS * `SMB_CYC_PER_MS)
`define SMB_HALF_CYC ((`SMB_HALF_BIT_NS * (`SMB_CLK_HZ / 1000000) + 999) / 1000)

`endif

/* smb_pkg.sv */
package smb_pkg;
  typedef enum logic {PROTO_PSMI, PROTO_PMBUS} proto_t;
  typedef enum logic [1:0] {TGT_CTRL, TGT_EE, TGT_ALERT} target_t;
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_RX, S_ACK, S_LOAD, S_TX, S_MACK, S_IGNORE
  } dev_state_t;
  typedef enum logic [3:0] {
    H_IDLE, H_START, H_LOW, H_HIGH, H_RS_LOW, H_RS_HIGH, H_STOP_LOW, H_STOP_HIGH, H_GAP
  } host_state_t;
  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_WRITE_READ} host_op_t;
endpackage

/* smb_if.sv */
`timescale 1ns/1ps
interface smb_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic dev_alert_o;
  logic dev_alert_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic scl;
  logic sda;
  logic fault_alert_n;

  // open-drain wires with external pull-ups: high unless someone drives
  assign scl = (dev_scl_oe ? dev_scl_o : 1'b1) & (host_scl_oe ? host_scl_o : 1'b1);
  assign sda = (dev_sda_oe ? dev_sda_o : 1'b1) & (host_sda_oe ? host_sda_o : 1'b1);
  assign fault_alert_n = dev_alert_oe ? dev_alert_o : 1'b1;

  modport device (input scl, input sda,
    output dev_scl_o, output dev_scl_oe, output dev_sda_o, output dev_sda_oe,
    output dev_alert_o, output dev_alert_oe);
  modport host (input scl, input sda, input fault_alert_n,
    output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

/* smb_line_sync.sv */
`timescale 1ns/1ps
module smb_line_sync (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic scl,
  output logic sda,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_cond,
  output logic stop_cond
);
  logic [1:0] scl_ff;
  logic [1:0] sda_ff;
  logic scl_d;
  logic sda_d;

  // two flops per pin; only stage two and its delayed copy feed the detectors
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_ff <= 2'h3;
      sda_ff <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_ff <= {scl_ff[0], scl_pin};
      sda_ff <= {sda_ff[0], sda_pin};
      scl_d <= scl_ff[1];
      sda_d <= sda_ff[1];
    end
  end

  // sda edges while scl stays high mark start and stop at any moment
  assign scl = scl_ff[1];
  assign sda = sda_ff[1];
  assign scl_rise = scl_ff[1] & ~scl_d;
  assign scl_fall = ~scl_ff[1] & scl_d;
  assign start_cond = scl_ff[1] & scl_d & sda_d & ~sda_ff[1];
  assign stop_cond = scl_ff[1] & scl_d & ~sda_d & sda_ff[1];
endmodule

/* smb_master.sv */
`timescale 1ns/1ps
`include "smb_cfg.svh"
module smb_master import smb_pkg::*; #(
  parameter int BUS_FREE_CYC = `SMB_BUS_FREE_CYC,
  parameter int HALF_CYC = `SMB_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  smb_if.host bus,
  input wire logic req_valid,
  output logic req_ready,
  input wire host_op_t req_op,
  input wire logic [6:0] req_addr,
  input wire logic [1:0] req_len,
  input wire logic [7:0] req_data0,
  input wire logic [7:0] req_data1,
  output logic resp_valid,
  output logic resp_nack,
  output logic [7:0] resp_data,
  output logic alert_seen
);
  localparam int CW = $clog2(((BUS_FREE_CYC > HALF_CYC) ? BUS_FREE_CYC : HALF_CYC) + 1);
  localparam logic [CW-1:0] HALF = CW'(HALF_CYC);
  localparam logic [CW-1:0] QTR = CW'(HALF_CYC / 2);

  host_state_t state;
  host_op_t op;
  logic [6:0] addr;
  logic [1:0] len;
  logic [7:0] d0;
  logic [7:0] d1;
  logic [CW-1:0] cnt;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic [2:0] pos;
  logic rx;
  logic scl_oe;
  logic sda_oe;
  logic scl_s;
  logic sda_s;
  logic [1:0] alert_ff;

  smb_line_sync u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .scl_pin(bus.scl),
    .sda_pin(bus.sda),
    .scl(scl_s),
    .sda(sda_s),
    .scl_rise(),
    .scl_fall(),
    .start_cond(),
    .stop_cond()
  );

  // alert pin crosses into this domain through two flops
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      alert_ff <= 2'h0;
    end else begin
      alert_ff <= {alert_ff[0], ~bus.fault_alert_n};
    end
  end
  assign alert_seen = alert_ff[1];

  assign req_ready = (state == H_IDLE) && scl_s && sda_s;

  // bit sequencer; high phase counts only once scl is seen high, so a stretch delays it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= H_IDLE;
      op <= OP_WRITE;
      addr <= 7'h00;
      len <= 2'h0;
      d0 <= 8'h00;
      d1 <= 8'h00;
      cnt <= '0;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      pos <= 3'h0;
      rx <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      resp_valid <= 1'b0;
      resp_nack <= 1'b0;
      resp_data <= 8'h00;
    end else begin
      resp_valid <= 1'b0;
      unique case (state)
        H_IDLE: begin
          if (req_valid && req_ready) begin
            op <= req_op;
            addr <= req_addr;
            len <= req_len;
            d0 <= req_data0;
            d1 <= req_data1;
            shreg <= {req_addr, req_op == OP_READ};
            rx <= 1'b0;
            pos <= 3'h0;
            bitcnt <= 4'h0;
            resp_nack <= 1'b0;
            sda_oe <= 1'b1;
            cnt <= '0;
            state <= H_START;
          end
        end
        H_START: begin
          cnt <= cnt + CW'(1);
          if (cnt == HALF) begin
            scl_oe <= 1'b1;
            cnt <= '0;
            state <= H_LOW;
          end
        end
        H_LOW: begin
          cnt <= cnt + CW'(1);
          if (cnt == QTR) begin
            // reads are single bytes, so the ack slot of a read is always a nack
            sda_oe <= (bitcnt == 4'h8 || rx) ? 1'b0 : ~shreg[7];
          end else if (cnt == HALF) begin
            scl_oe <= 1'b0;
            cnt <= '0;
            state <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (scl_s) begin
            cnt <= cnt + CW'(1);
          end
          if (cnt == HALF) begin
            cnt <= '0;
            scl_oe <= 1'b1;
            state <= H_LOW;
            if (bitcnt != 4'h8) begin
              shreg <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end else begin
              bitcnt <= 4'h0;
              pos <= pos + 3'h1;
              rx <= 1'b0;
              if (!rx && sda_s) begin
                resp_nack <= 1'b1;
                state <= H_STOP_LOW;
              end else if (rx) begin
                resp_data <= shreg;
                state <= H_STOP_LOW;
              end else if (op == OP_READ) begin
                rx <= 1'b1;
              end else if (op == OP_WRITE) begin
                if (pos < {1'b0, len}) begin
                  shreg <= (pos == 3'h0) ? d0 : d1;
                end else begin
                  state <= H_STOP_LOW;
                end
              end else if (pos == 3'h0) begin
                shreg <= d0;
              end else if (pos == 3'h1) begin
                shreg <= {addr, 1'b1};
                state <= H_RS_LOW;
              end else begin
                rx <= 1'b1;
              end
            end
          end
        end
        H_RS_LOW, H_STOP_LOW: begin
          cnt <= cnt + CW'(1);
          if (cnt == QTR) begin
            sda_oe <= (state == H_STOP_LOW);
          end else if (cnt == HALF) begin
            scl_oe <= 1'b0;
            cnt <= '0;
            state <= (state == H_RS_LOW) ? H_RS_HIGH : H_STOP_HIGH;
          end
        end
        H_RS_HIGH, H_STOP_HIGH: begin
          if (scl_s) begin
            cnt <= cnt + CW'(1);
          end
          if (cnt == HALF) begin
            cnt <= '0;
            sda_oe <= (state == H_RS_HIGH);
            resp_valid <= (state == H_STOP_HIGH);
            state <= (state == H_RS_HIGH) ? H_START : H_GAP;
          end
        end
        H_GAP: begin
          // bus free time covers the eeprom's internal write after a stop
          cnt <= cnt + CW'(1);
          if (cnt == CW'(BUS_FREE_CYC)) begin
            cnt <= '0;
            state <= H_IDLE;
          end
        end
      endcase
    end
  end

  // half period of 5 us keeps the clock at or below 100 kHz
  assign bus.host_scl_oe = scl_oe;
  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_oe = sda_oe;
  assign bus.host_sda_o = 1'b0;
endmodule

/* smb_props.sv */
`timescale 1ns/1ps
module smb_props #(
  parameter int STRETCH_CYC = 100,
  parameter int BUS_FREE_CYC = 50
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic fault_alert_n,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic host_sda_oe,
  input wire logic [7:0] shutdown_events,
  input wire logic [7:0] warning_events
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic any_ev;
  logic sda_q;
  logic [19:0] free_cnt;
  // either group alone must pull the alert line
  assign any_ev = (|shutdown_events) || (|warning_events);
  always_ff @(posedge ref_clk) begin
    sda_q <= sda;
  end
  // cycles since the last stop; saturates so an old stop never wraps
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      free_cnt <= 20'hfffff;
    end else if (scl && sda && !sda_q) begin
      free_cnt <= 20'h0;
    end else if (free_cnt != 20'hfffff) begin
      free_cnt <= free_cnt + 20'h1;
    end
  end
  a_start_by_host: assert property (scl && $fell(sda) |-> host_sda_oe)
    else $error("start not made by the host");
  a_stretch_from_low: assert property ($rose(dev_scl_oe) |-> !$past(scl))
    else $error("target pulled a high clock low");
  a_stretch_bound: assert property ($rose(dev_scl_oe) |-> ##[1:STRETCH_CYC] !dev_scl_oe)
    else $error("clock stretch too long");
  a_sda_low_phase: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("target moved data while clock high");
  a_alert_set: assert property ($rose(any_ev) |-> ##[0:3] !fault_alert_n)
    else $error("alert not raised");
  a_alert_clear: assert property ($fell(any_ev) |-> ##[0:3] fault_alert_n)
    else $error("alert not released");
  a_bus_free: assert property (scl && $fell(sda) |-> free_cnt >= BUS_FREE_CYC)
    else $error("start too soon after stop");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  cover property ($rose(dev_scl_oe));
  cover property ($rose(dev_sda_oe));
  cover property (!fault_alert_n);
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb
  import smb_pkg::*;
;
  typedef struct packed {logic nack; logic rd; logic [7:0] data;} resp_exp_t;
  localparam int TO_CYC = 2000;
  logic ref_clk;
  logic reset = 1'b1;
  logic [17:0] sel_res = 18'h0;
  logic sel_open = 1'b0;
  logic [7:0] sd_ev = 8'h0;
  logic [7:0] wr_ev = 8'h0;
  logic [7:0] status = 8'h0;
  logic req_valid = 1'b0;
  host_op_t req_op = OP_WRITE;
  logic [6:0] req_addr = 7'h0;
  logic [1:0] req_len = 2'h1;
  logic [7:0] req_d0 = 8'h0;
  logic [7:0] req_d1 = 8'h0;
  logic req_ready, resp_valid, resp_nack, alert_seen, write_protect, cmd_valid;
  logic [7:0] resp_data, cmd_code;
  logic [6:0] ctrl_addr, ee_addr, ee_addr_b;
  proto_t proto;
  int errors = 0;
  int compares = 0;
  int cmd_n = 0;
  resp_exp_t exp_q[$];
  resp_exp_t cur;
  logic [17:0] res_tab [8] = '{18'h334, 18'ha8c, 18'h15e0, 18'h2008, 18'h3a98, 18'h6978, 18'hdac0, 18'h2bf20};
  smb_if bus();
  smb_if bus_b();
  // the bench plays the host on the second bus, open drain like the real one
  assign bus_b.host_scl_o = 1'b0;
  assign bus_b.host_sda_o = 1'b0;
  smb_target #(.STRETCH_CYC(100), .TIMEOUT_CYC(TO_CYC)) u_smb_target (.ref_clk(ref_clk), .reset(reset),
    .bus(bus.device), .select_resistor_value(sel_res), .select_pin_open(sel_open), .shutdown_events(sd_ev),
    .warning_events(wr_ev), .status_byte(status), .proto(proto), .ctrl_addr(ctrl_addr), .ee_addr(ee_addr),
    .write_protect(write_protect), .cmd_valid(cmd_valid), .cmd_code(cmd_code));
  smb_target #(.STRETCH_CYC(100), .TIMEOUT_CYC(TO_CYC)) u_smb_target_b (.ref_clk(ref_clk), .reset(reset),
    .bus(bus_b.device), .select_resistor_value(sel_res), .select_pin_open(sel_open), .shutdown_events(sd_ev),
    .warning_events(wr_ev), .status_byte(status), .proto(), .ctrl_addr(), .ee_addr(ee_addr_b), .write_protect(),
    .cmd_valid(), .cmd_code());
  smb_master #(.BUS_FREE_CYC(50), .HALF_CYC(100)) u_smb_master (.ref_clk(ref_clk), .reset(reset), .bus(bus.host),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_len(req_len),
    .req_data0(req_d0), .req_data1(req_d1), .resp_valid(resp_valid), .resp_nack(resp_nack),
    .resp_data(resp_data), .alert_seen(alert_seen));
  smb_props #(.STRETCH_CYC(100), .BUS_FREE_CYC(50)) u_smb_props (.ref_clk(ref_clk), .reset(reset), .scl(bus.scl),
    .sda(bus.sda), .fault_alert_n(bus.fault_alert_n), .dev_scl_oe(bus.dev_scl_oe), .dev_sda_oe(bus.dev_sda_oe),
    .host_sda_oe(bus.host_sda_oe), .shutdown_events(sd_ev), .warning_events(wr_ev));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // note the answer first, then hold the request until the edge that takes it
  task automatic send(input host_op_t op, input logic [6:0] a, input logic [7:0] d0, input logic [7:0] d1,
      input logic [1:0] len, input resp_exp_t e);
    int n;
    n = 0;
    exp_q.push_back(e);
    req_op <= op;
    req_addr <= a;
    req_d0 <= d0;
    req_d1 <= d1;
    req_len <= len;
    req_valid <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!req_ready && n < 40000);
    if (n >= 40000) begin
      errors++;
      report_and_stop();
    end
    req_valid <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 40000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 40000) begin
      errors++;
      report_and_stop();
    end
    @(posedge ref_clk);
  endtask
  // each response retires the oldest note
  always @(posedge ref_clk) begin
    cmd_n += int'(cmd_valid === 1'b1);
    if (resp_valid) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("Error at %0t: unexpected response", $time);
      end else begin
        cur = exp_q.pop_front();
        chk(8'(resp_nack), 8'(cur.nack));
        if (cur.rd) begin
          chk(resp_data, cur.data);
        end
      end
    end
  end
  // pull scl before sda moves so no false start or stop is seen
  task automatic hold(input logic c, input logic d, input int cyc);
    bus_b.host_scl_oe <= c;
    bus_b.host_sda_oe <= d;
    repeat (cyc) @(posedge ref_clk);
  endtask
  task automatic bbit(input logic b);
    hold(1'b1, bus_b.host_sda_oe, 25);
    hold(1'b1, !b, 25);
    hold(1'b0, !b, 50);
  endtask
  task automatic bstart();
    hold(1'b1, bus_b.host_sda_oe, 25);
    hold(1'b1, 1'b0, 25);
    hold(1'b0, 1'b0, 50);
    hold(1'b0, 1'b1, 50);
  endtask
  // ends in the ack slot with scl low and sda released
  task automatic bbyte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      bbit(v[i]);
    end
    hold(1'b1, bus_b.host_sda_oe, 25);
    hold(1'b1, 1'b0, 25);
  endtask
  initial begin
    int sel;
    logic [6:0] ctrl_e, ee_e;
    logic [7:0] loc, dat;
    bus_b.host_scl_oe = 1'b0;
    bus_b.host_sda_oe = 1'b0;
    void'($urandom(32'h1fc1));
    sel = $urandom_range(8, 0);
    ctrl_e = 7'h58 + ((sel == 8) ? 7'h3 : 7'(sel % 4));
    ee_e = ctrl_e - 7'h8;
    loc = 8'($urandom());
    dat = 8'($urandom());
    sel_res <= (sel == 8) ? 18'h3ffff : res_tab[sel % 8];
    sel_open <= (sel == 8);
    status <= 8'($urandom());
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (20) @(posedge ref_clk);
    chk(8'(write_protect), 8'h1);
    // a strap change after start-up must not move anything
    for (int k = 0; k < 2; k++) begin
      chk(8'(proto), 8'((sel < 4) ? PROTO_PMBUS : PROTO_PSMI));
      chk(8'(ctrl_addr), 8'(ctrl_e));
      chk(8'(ee_addr), 8'(ee_e));
      chk(8'(ee_addr_b), 8'(ee_e));
      sel_res <= res_tab[(sel + 1) % 8];
      sel_open <= (sel != 8);
      repeat (20) @(posedge ref_clk);
    end
    $display("strap test done");
    for (int g = 0; g < 2; g++) begin
      sd_ev <= g ? 8'h0 : 8'h1 << $urandom_range(7, 0);
      wr_ev <= g ? 8'h1 << $urandom_range(7, 0) : 8'h0;
      repeat (10) @(posedge ref_clk);
      chk(8'(alert_seen), 8'h1);
      sd_ev <= 8'h0;
      wr_ev <= 8'h0;
      repeat (10) @(posedge ref_clk);
      chk(8'(alert_seen), 8'h0);
    end
    $display("alert test done");
    send(OP_WRITE, ctrl_e, 8'hd0, 8'h0, 2'h1, '{1'b0, 1'b0, 8'h0});
    drain();
    chk(8'(write_protect), 8'h0);
    chk(cmd_code, 8'hd0);
    send(OP_WRITE, ee_e, loc, dat, 2'h2, '{1'b0, 1'b0, 8'h0});
    send(OP_WRITE, ctrl_e, 8'hd1, 8'h0, 2'h1, '{1'b0, 1'b0, 8'h0});
    send(OP_WRITE, ee_e, loc, ~dat, 2'h2, '{1'b0, 1'b0, 8'h0});
    send(OP_WRITE_READ, ee_e, loc, 8'h0, 2'h1, '{1'b0, 1'b1, dat});
    send(OP_READ, 7'h0c, 8'h0, 8'h0, 2'h1, '{1'b0, 1'b1, status});
    send(OP_READ, ctrl_e, 8'h0, 8'h0, 2'h1, '{1'b0, 1'b1, status});
    send(OP_WRITE, 7'h20 | 7'($urandom_range(15, 0)), 8'h0, 8'h0, 2'h1, '{1'b1, 1'b0, 8'h0});
    send(OP_WRITE, 7'h0c, 8'h0, 8'h0, 2'h1, '{1'b1, 1'b0, 8'h0});
    drain();
    chk(8'(write_protect), 8'h1);
    chk(8'(cmd_n), 8'h2);
    $display("transfer test done");
    // restart mid-byte, then a host that stalls scl past the limit
    bstart();
    bbit(1'b1);
    bbit(1'b0);
    bbit(1'b1);
    bstart();
    bbyte({ee_e, 1'b0});
    chk(8'(bus_b.sda), 8'h0);
    hold(1'b1, 1'b0, TO_CYC + 20);
    chk(8'(bus_b.sda), 8'h1);
    hold(1'b0, 1'b0, 50);
    bstart();
    bbyte({ee_e, 1'b0});
    chk(8'(bus_b.sda), 8'h0);
    $display("timeout test done");
    report_and_stop();
  end
endmodule
